// ### verilog/mwd_detect.sv
/*
 * Mechanical weakening detector with its torque detection channel one and
 * an AHB-Lite register slave with sticky event status and interrupt.
 * Assumes speed, torque, run, speed-agree and operation hours come from
 * logic on i_ref_clk; speed and speed level in 0.1 % units, torque and its level in 1 % units.
 */
// Implementation choice: register access over AHB-Lite.
//Behaviour
//R1: Mode 0 to 8, reset 0; mode 0 never raises alarm or fault.
//R2: Modes 1,2: speed above level gives alarm only; 1 signed, 2 magnitude.
//R3: Modes 3,4: speed above level gives fault, output off; 3 signed, 4 magnitude.
//R4: Modes 5,6: speed below level gives alarm only; 5 signed, 6 magnitude.
//R5: Modes 7,8: speed below level gives fault, output off; 7 signed, 8 magnitude.
//R6: Magnitude modes compare against magnitude of a negative speed level.
//R7: Speed level -110.0 to 110.0 % in 0.1 steps, reset 110.0 %.
//R8: Raise only after condition persists for detection time, 0.0-10.0 s, default 0.1 s.
//R9: Detection inactive until operation hours reach start time, 0-65535, default 0.
//R10: Torque condition comes from torque channel one with its selection and time.
//R11: Channel one reports only after torque beyond level lasts its time, default 0.1 s.
//R12: Timer clears when condition drops; fault holds until a fault reset.
module mwd_detect #(
   parameter int P_TENTH_CYCLES = mwd_pkg::TENTH_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic signed [15:0] i_speed,
   input wire logic signed [15:0] i_torque,
   input wire logic i_run,
   input wire logic i_speed_agree,
   input wire logic [15:0] i_operation_hours,
   output logic o_overtorque_detect_one,
   output logic o_weak_alarm,
   output logic o_weak_fault,
   output logic o_drive_stop,
   output logic o_irq
);
   localparam logic [mwd_pkg::SUB_W-1:0] SUB_LAST = (mwd_pkg::SUB_W)'(P_TENTH_CYCLES - 1);

   typedef struct packed {
      logic [3:0] mode;
      logic [15:0] speed_level;
      logic [15:0] detect_time;
      logic [15:0] start_hours;
      logic [3:0] tq_select;
      logic [15:0] tq_level;
      logic [15:0] tq_time;
      logic [mwd_pkg::EVT_W-1:0] status;
      logic [mwd_pkg::EVT_W-1:0] mask;
      logic fault;
      logic alarm;
      logic tq_det;
      logic [mwd_pkg::SUB_W-1:0] tq_sub;
      logic [15:0] tq_cnt;
      logic [mwd_pkg::SUB_W-1:0] wk_sub;
      logic [15:0] wk_cnt;
      logic wr_pend;
      logic rd_wait;
      logic [11:0] idx;
      logic mapped;
      logic [31:0] rdata;
   } mwd_state_t;

   mwd_state_t st;
   mwd_state_t next_st;

   // Register selected by the index latched in the address phase
   typedef enum logic [3:0] {
      MWD_REG_NONE = 4'h0,
      MWD_REG_MODE = 4'h1,
      MWD_REG_SPEED = 4'h2,
      MWD_REG_TIME = 4'h3,
      MWD_REG_HOURS = 4'h4,
      MWD_REG_TQ_SELECT = 4'h5,
      MWD_REG_TQ_LEVEL = 4'h6,
      MWD_REG_TQ_TIME = 4'h7,
      MWD_REG_STATUS = 4'h8,
      MWD_REG_MASK = 4'h9,
      MWD_REG_CONTROL = 4'hA
   } mwd_reg_t;

   // One decode for the write and read paths, so both always see the same map
   function automatic mwd_reg_t mwd_decode(input logic mapped, input logic [11:0] idx);
      mwd_reg_t r;
      r = MWD_REG_NONE;
      if (!mapped) begin
         r = MWD_REG_NONE;
      end else if (idx == mwd_pkg::IDX_WEAK_MODE) begin
         r = MWD_REG_MODE;
      end else if (idx == mwd_pkg::IDX_WEAK_SPEED) begin
         r = MWD_REG_SPEED;
      end else if (idx == mwd_pkg::IDX_WEAK_TIME) begin
         r = MWD_REG_TIME;
      end else if (idx == mwd_pkg::IDX_WEAK_HOURS) begin
         r = MWD_REG_HOURS;
      end else if (idx == mwd_pkg::IDX_TQ_SELECT) begin
         r = MWD_REG_TQ_SELECT;
      end else if (idx == mwd_pkg::IDX_TQ_LEVEL) begin
         r = MWD_REG_TQ_LEVEL;
      end else if (idx == mwd_pkg::IDX_TQ_TIME) begin
         r = MWD_REG_TQ_TIME;
      end else if (idx == mwd_pkg::IDX_STATUS) begin
         r = MWD_REG_STATUS;
      end else if (idx == mwd_pkg::IDX_MASK) begin
         r = MWD_REG_MASK;
      end else if (idx == mwd_pkg::IDX_CONTROL) begin
         r = MWD_REG_CONTROL;
      end
      return r;
   endfunction

   function automatic logic [16:0] mwd_abs(input logic signed [15:0] v);
      logic signed [16:0] w;
      w = 17'(v);
      return (w < 0) ? 17'(-w) : 17'(w);
   endfunction

   // Persistence timer: counts whole tenths while the condition holds
   function automatic logic [mwd_pkg::SUB_W+15:0] mwd_timer(input logic cond,
         input logic [mwd_pkg::SUB_W-1:0] sub, input logic [15:0] cnt);
      logic [mwd_pkg::SUB_W-1:0] s;
      logic [15:0] c;
      s = '0;
      c = '0;
      if (cond) begin
         s = sub + 1'b1;
         c = cnt;
         if (sub == SUB_LAST) begin
            s = '0;
            if (cnt != 16'hFFFF) begin
               c = cnt + 16'h0001;
            end
         end
      end
      return {s, c};
   endfunction

   logic [16:0] abs_speed;
   logic [16:0] abs_level;
   logic [16:0] abs_torque;
   logic signed [16:0] wdata_s;
   logic tq_cond;
   logic speed_cond;
   logic weak_cond;
   logic fire;
   logic fault_mode;
   logic [mwd_pkg::EVT_W-1:0] evt;
   logic addr_ok;
   mwd_reg_t reg_sel;

   always_comb begin
      abs_speed = mwd_abs(i_speed);
      abs_level = mwd_abs(st.speed_level);
      abs_torque = mwd_abs(i_torque);
      wdata_s = 17'(signed'(i_hwdata[15:0]));
      // Channel one: odd selections only while at speed, even ones whole run
      tq_cond = 1'b0;
      if (st.tq_select != 4'h0 && i_run && (i_speed_agree || !st.tq_select[0])) begin
         if (st.tq_select <= mwd_pkg::MODE_LAST_ABOVE) begin
            tq_cond = abs_torque > 17'(st.tq_level);
         end else begin
            tq_cond = abs_torque < 17'(st.tq_level);
         end
      end
      // Odd modes compare signed, even modes magnitudes  [R2] [R4] [R6]
      speed_cond = 1'b0;
      if (st.mode[0]) begin
         if (st.mode <= mwd_pkg::MODE_LAST_ABOVE) begin
            speed_cond = $signed(i_speed) > $signed(st.speed_level);  // [R2] [R3]
         end else begin
            speed_cond = $signed(i_speed) < $signed(st.speed_level);  // [R4] [R5]
         end
      end else begin
         if (st.mode <= mwd_pkg::MODE_LAST_ABOVE) begin
            speed_cond = abs_speed > abs_level;  // [R2] [R3] [R6]
         end else begin
            speed_cond = abs_speed < abs_level;  // [R4] [R5] [R6]
         end
      end
      weak_cond = (st.mode != 4'h0) && speed_cond && st.tq_det  // [R1] [R10]
         && (i_operation_hours >= st.start_hours);  // [R9]
      fire = weak_cond && (st.wk_cnt >= st.detect_time);  // [R8]
      fault_mode = (st.mode == 4'h3) || (st.mode == 4'h4) || (st.mode >= 4'h7);  // [R3] [R5]
      evt = '0;
      evt[mwd_pkg::BIT_ALARM] = fire && !fault_mode;
      evt[mwd_pkg::BIT_FAULT] = fire && fault_mode;
      addr_ok = (i_haddr[31:14] == 18'h0_0000);
      reg_sel = mwd_decode(st.mapped, st.idx);
   end

   always_comb begin
      next_st = st;
      // Torque channel one persistence  [R11]
      {next_st.tq_sub, next_st.tq_cnt} = mwd_timer(tq_cond, st.tq_sub, st.tq_cnt);
      next_st.tq_det = tq_cond && (next_st.tq_cnt >= st.tq_time);  // [R10] [R11]
      // Dropout of the condition restarts the wait  [R12]
      {next_st.wk_sub, next_st.wk_cnt} = mwd_timer(weak_cond, st.wk_sub, st.wk_cnt);
      next_st.alarm = evt[mwd_pkg::BIT_ALARM];  // [R2] [R4]
      next_st.rd_wait = 1'b0;
      next_st.wr_pend = 1'b0;
      // Register write in the data phase
      if (st.wr_pend) begin
         if (reg_sel == MWD_REG_MODE) begin
            if (i_hwdata[15:0] <= 16'(mwd_pkg::MODE_MAX)) begin  // [R1]
               next_st.mode = i_hwdata[3:0];
            end
         end else if (reg_sel == MWD_REG_SPEED) begin
            if (wdata_s <= mwd_pkg::SPEED_MAX && wdata_s >= -mwd_pkg::SPEED_MAX) begin  // [R7]
               next_st.speed_level = i_hwdata[15:0];
            end
         end else if (reg_sel == MWD_REG_TIME) begin
            if (i_hwdata[15:0] <= mwd_pkg::TIME_MAX) begin  // [R8]
               next_st.detect_time = i_hwdata[15:0];
            end
         end else if (reg_sel == MWD_REG_HOURS) begin
            next_st.start_hours = i_hwdata[15:0];  // [R9]
         end else if (reg_sel == MWD_REG_TQ_SELECT) begin
            if (i_hwdata[15:0] <= 16'(mwd_pkg::MODE_MAX)) begin
               next_st.tq_select = i_hwdata[3:0];
            end
         end else if (reg_sel == MWD_REG_TQ_LEVEL) begin
            if (i_hwdata[15:0] <= mwd_pkg::TQ_LEVEL_MAX) begin
               next_st.tq_level = i_hwdata[15:0];
            end
         end else if (reg_sel == MWD_REG_TQ_TIME) begin
            if (i_hwdata[15:0] <= mwd_pkg::TIME_MAX) begin  // [R11]
               next_st.tq_time = i_hwdata[15:0];
            end
         end else if (reg_sel == MWD_REG_STATUS) begin
            next_st.status = st.status & ~i_hwdata[mwd_pkg::EVT_W-1:0];
         end else if (reg_sel == MWD_REG_MASK) begin
            next_st.mask = i_hwdata[mwd_pkg::EVT_W-1:0];
         end else if (reg_sel == MWD_REG_CONTROL) begin
            if (i_hwdata[mwd_pkg::BIT_FAULT_RESET]) begin
               next_st.fault = 1'b0;  // [R12]
            end
         end
      end
      // Events win over a clear in the same cycle
      next_st.status = next_st.status | evt;
      if (evt[mwd_pkg::BIT_FAULT]) begin
         next_st.fault = 1'b1;  // [R3] [R5] [R12]
      end
      // Reads take one wait state so a write just before is already visible
      if (st.rd_wait) begin
         next_st.rdata = '0;
         if (reg_sel == MWD_REG_MODE) begin
            next_st.rdata = 32'(st.mode);
         end else if (reg_sel == MWD_REG_SPEED) begin
            next_st.rdata = {16'h0000, st.speed_level};
         end else if (reg_sel == MWD_REG_TIME) begin
            next_st.rdata = {16'h0000, st.detect_time};
         end else if (reg_sel == MWD_REG_HOURS) begin
            next_st.rdata = {16'h0000, st.start_hours};
         end else if (reg_sel == MWD_REG_TQ_SELECT) begin
            next_st.rdata = 32'(st.tq_select);
         end else if (reg_sel == MWD_REG_TQ_LEVEL) begin
            next_st.rdata = {16'h0000, st.tq_level};
         end else if (reg_sel == MWD_REG_TQ_TIME) begin
            next_st.rdata = {16'h0000, st.tq_time};
         end else if (reg_sel == MWD_REG_STATUS) begin
            next_st.rdata = 32'(st.status);
         end else if (reg_sel == MWD_REG_MASK) begin
            next_st.rdata = 32'(st.mask);
         end
      end
      // Address phase
      if (i_hsel && i_htrans[1] && i_hready) begin
         next_st.idx = i_haddr[13:2];
         next_st.mapped = addr_ok;
         next_st.wr_pend = i_hwrite;
         next_st.rd_wait = !i_hwrite;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
         st.mode <= mwd_pkg::RST_WEAK_MODE;  // [R1]
         st.speed_level <= mwd_pkg::RST_WEAK_SPEED;  // [R7]
         st.detect_time <= mwd_pkg::RST_WEAK_TIME;  // [R8]
         st.start_hours <= mwd_pkg::RST_WEAK_HOURS;  // [R9]
         st.tq_select <= mwd_pkg::RST_TQ_SELECT;
         st.tq_level <= mwd_pkg::RST_TQ_LEVEL;
         st.tq_time <= mwd_pkg::RST_TQ_TIME;  // [R11]
      end else begin
         st <= next_st;
      end
   end

   assign o_hrdata = st.rdata;
   assign o_hreadyout = !st.rd_wait;
   assign o_hresp = 1'b0;
   assign o_overtorque_detect_one = st.tq_det;
   assign o_weak_alarm = st.alarm;
   assign o_weak_fault = st.fault;
   assign o_drive_stop = st.fault;  // [R3] [R5]
   assign o_irq = |(st.status & st.mask);
endmodule

// ### verilog/mwd_pkg.sv
/*
 * Constants for the mechanical weakening detector: register indices, field
 * layouts, reset values, setting ranges and timing.
 * Assumes a 50 MHz clock and a word-wide AHB-Lite register window.
 */
package mwd_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [11:0] IDX_WEAK_MODE = 12'h0468;
   localparam logic [11:0] IDX_WEAK_SPEED = 12'h0469;
   localparam logic [11:0] IDX_WEAK_TIME = 12'h046A;
   localparam logic [11:0] IDX_WEAK_HOURS = 12'h046B;
   localparam logic [11:0] IDX_TQ_SELECT = 12'h04A1;
   localparam logic [11:0] IDX_TQ_LEVEL = 12'h04A2;
   localparam logic [11:0] IDX_TQ_TIME = 12'h04A3;
   localparam logic [11:0] IDX_STATUS = 12'h0470;
   localparam logic [11:0] IDX_MASK = 12'h0471;
   localparam logic [11:0] IDX_CONTROL = 12'h0472;

   // Reset values
   localparam logic [3:0] RST_WEAK_MODE = 4'h0;
   localparam logic [15:0] RST_WEAK_SPEED = 16'h044C;
   localparam logic [15:0] RST_WEAK_TIME = 16'h0001;
   localparam logic [15:0] RST_WEAK_HOURS = 16'h0000;
   localparam logic [3:0] RST_TQ_SELECT = 4'h0;
   localparam logic [15:0] RST_TQ_LEVEL = 16'h0096;
   localparam logic [15:0] RST_TQ_TIME = 16'h0001;

   // Setting ranges
   localparam logic [3:0] MODE_MAX = 4'h8;
   localparam logic [3:0] MODE_LAST_ABOVE = 4'h4;
   localparam logic signed [16:0] SPEED_MAX = 17'sh0_044C;
   localparam logic [15:0] TIME_MAX = 16'h0064;
   localparam logic [15:0] TQ_LEVEL_MAX = 16'h012C;

   // Status, mask and control bits
   localparam int BIT_ALARM = 0;
   localparam int BIT_FAULT = 1;
   localparam int BIT_FAULT_RESET = 0;
   localparam int EVT_W = 2;

   // Time base: settings count in tenths of a second
   localparam longint CLK_PERIOD_NS = 20;
   localparam longint TENTH_NS = 100_000_000;
   localparam int TENTH_CYCLES = int'(TENTH_NS / CLK_PERIOD_NS);
   localparam int SUB_W = 23;
endpackage

// ### tb/mwd_detect_checker.sv
/* Checker for the weakening detector: bus timing and output relations.
   Assumes it is bound into mwd_detect and sees only its ports. */
module mwd_detect_checker (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic i_run,
   input wire logic o_overtorque_detect_one,
   input wire logic o_weak_alarm,
   input wire logic o_weak_fault,
   input wire logic o_drive_stop,
   input wire logic o_irq
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   logic tk;
   assign tk = i_hsel && i_htrans[1] && i_hready;
   a_resp_okay: assert property (o_hresp == 1'b0)
      else $error("hresp not okay");
   a_read_wait: assert property (tk && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (tk && i_hwrite |=> o_hreadyout)
      else $error("write stalled");
   a_wait_cause: assert property (!o_hreadyout |-> $past(tk && !i_hwrite))
      else $error("stall without read");
   a_rdata_stands: assert property ($changed(o_hrdata) |-> !$past(o_hreadyout))
      else $error("read data moved");
   a_stop_fault: assert property (o_drive_stop == o_weak_fault)
      else $error("stop differs from fault");
   // A fault may only fall after a control write two edges back
   a_fault_hold: assert property ($fell(o_weak_fault) |->
      $past(tk && i_hwrite && i_haddr[13:2] == mwd_pkg::IDX_CONTROL, 2))
      else $error("fault dropped without reset");
   a_alarm_torque: assert property (o_weak_alarm |-> $past(o_overtorque_detect_one))
      else $error("alarm without torque detect");
   a_torque_run: assert property ($rose(o_overtorque_detect_one) |-> $past(i_run))
      else $error("torque detect while stopped");
   // A new interrupt needs a fresh event or a register write two edges back
   a_irq_cause: assert property ($rose(o_irq) |->
      (o_weak_alarm || o_weak_fault || $past(tk && i_hwrite, 2)))
      else $error("interrupt without event");
   c_alarm: cover property ($rose(o_weak_alarm));
   c_fault: cover property ($rose(o_weak_fault));
   c_fault_clr: cover property ($fell(o_weak_fault));
endmodule

bind mwd_detect mwd_detect_checker u_chk (
   .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_run(i_run),
   .o_overtorque_detect_one(o_overtorque_detect_one), .o_weak_alarm(o_weak_alarm),
   .o_weak_fault(o_weak_fault), .o_drive_stop(o_drive_stop), .o_irq(o_irq)
);

// ### tb/tb.sv
/* Testbench for mwd_detect: register tasks on AHB-Lite, speed and torque stimulus.
   Assumes mwd_pkg, mwd_detect and the bound checker are compiled first. */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_ref_clk = 0, i_rstn = 0, i_hsel = 0, i_hwrite = 0, i_run = 1, i_speed_agree = 1;
   logic [1:0] i_htrans = 2'h0;
   logic [2:0] i_hsize = 3'h2;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, d;
   logic signed [15:0] i_speed = 16'h0, i_torque = 16'h0;
   logic [15:0] i_operation_hours = 16'h0, lv, sp;
   logic o_hreadyout, o_hresp, o_overtorque_detect_one, o_weak_alarm, o_weak_fault;
   logic o_drive_stop, o_irq, al;
   logic [31:0] rv [4] = '{32'h0, 32'h0000_044C, 32'h1, 32'h0};
   int n_errors = 0, num_checks = 0, cyc = 0;
   // Short tenth-second so the persistence windows take a few cycles
   mwd_detect #(.P_TENTH_CYCLES(4)) uut (
      .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp), .i_speed(i_speed), .i_torque(i_torque), .i_run(i_run),
      .i_speed_agree(i_speed_agree), .i_operation_hours(i_operation_hours),
      .o_overtorque_detect_one(o_overtorque_detect_one), .o_weak_alarm(o_weak_alarm),
      .o_weak_fault(o_weak_fault), .o_drive_stop(o_drive_stop), .o_irq(o_irq)
   );
   always #10 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", s, e, g);
      end
   endtask
   // Each phase stands until hready is seen high at a rising edge
   task automatic bus(input logic [11:0] x, input logic w, input logic [31:0] v);
      @(posedge i_ref_clk);
      i_hsel <= 1'b1;
      i_haddr <= {18'h0_0000, x, 2'b00};
      i_htrans <= 2'h2;
      i_hwrite <= w;
      do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= v;
      do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
      d = o_hrdata;
      chk("hresp", 32'h0, {31'h0, o_hresp});
   endtask
   task automatic setin(input logic [15:0] s, input logic [15:0] q, input logic [15:0] h);
      @(posedge i_ref_clk);
      i_speed <= s;
      i_torque <= q;
      i_operation_hours <= h;
   endtask
   task automatic outs(input int n, input logic a, input logic f);
      repeat (n) @(negedge i_ref_clk);
      chk("alarm", {31'h0, a}, {31'h0, o_weak_alarm});
      chk("fault", {31'h0, f}, {31'h0, o_weak_fault});
      chk("drive stop", {31'h0, f}, {31'h0, o_drive_stop});
   endtask
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         bus(mwd_pkg::IDX_WEAK_MODE + 12'(k), 1'b0, 32'h0);
         chk("reset value", rv[k], d);
      end
      bus(12'hFFF, 1'b0, 32'h0);
      chk("unmapped", 32'h0, d);
      bus(mwd_pkg::IDX_WEAK_MODE, 1'b1, 32'h9);
      bus(mwd_pkg::IDX_WEAK_SPEED, 1'b1, 32'h0000_044D);
      bus(mwd_pkg::IDX_WEAK_MODE, 1'b0, 32'h0);
      chk("mode range", 32'h0, d);
      bus(mwd_pkg::IDX_WEAK_SPEED, 1'b0, 32'h0);
      chk("level range", 32'h0000_044C, d);
      bus(mwd_pkg::IDX_TQ_SELECT, 1'b1, 32'h2);
      bus(mwd_pkg::IDX_TQ_TIME, 1'b1, 32'h0);
      bus(mwd_pkg::IDX_WEAK_TIME, 1'b1, 32'h0);
      bus(mwd_pkg::IDX_MASK, 1'b1, 32'h3);
      setin(16'h0258, 16'h00C8, 16'h0);
      outs(6, 1'b0, 1'b0);
      // Even modes use negative speed and level: a signed compare would miss
      for (int m = 1; m <= 8; m++) begin
         al = m inside {1, 2, 5, 6};
         lv = m[0] ? 16'h01F4 : 16'hFE0C;
         sp = (m <= 4) ? (m[0] ? 16'h0258 : 16'hFDA8) : (m[0] ? 16'h0190 : 16'hFE70);
         bus(mwd_pkg::IDX_WEAK_SPEED, 1'b1, {16'h0, lv});
         setin(sp, 16'h00C8, 16'h0);
         bus(mwd_pkg::IDX_WEAK_MODE, 1'b1, 32'(m));
         outs(4, al, !al);
         chk("irq", 32'h1, {31'h0, o_irq});
         bus(mwd_pkg::IDX_WEAK_MODE, 1'b1, 32'h0);
         outs(3, 1'b0, !al);
         bus(mwd_pkg::IDX_STATUS, 1'b0, 32'h0);
         chk("status", al ? 32'h1 : 32'h2, d);
         bus(mwd_pkg::IDX_CONTROL, 1'b1, 32'h1);
         bus(mwd_pkg::IDX_STATUS, 1'b1, 32'h3);
         outs(2, 1'b0, 1'b0);
         chk("irq clear", 32'h0, {31'h0, o_irq});
      end
      bus(mwd_pkg::IDX_WEAK_SPEED, 1'b1, 32'h0000_01F4);
      setin(16'h0258, 16'h00C8, 16'h0);
      bus(mwd_pkg::IDX_WEAK_TIME, 1'b1, 32'h2);
      bus(mwd_pkg::IDX_MASK, 1'b1, 32'h0);
      bus(mwd_pkg::IDX_WEAK_MODE, 1'b1, 32'h1);
      outs(4, 1'b0, 1'b0);
      setin(16'h0258, 16'h0064, 16'h0);
      setin(16'h0258, 16'h00C8, 16'h0);
      outs(6, 1'b0, 1'b0);
      outs(6, 1'b1, 1'b0);
      chk("irq masked", 32'h0, {31'h0, o_irq});
      bus(mwd_pkg::IDX_WEAK_TIME, 1'b1, 32'h0);
      bus(mwd_pkg::IDX_WEAK_HOURS, 1'b1, 32'h0000_0064);
      setin(16'h0258, 16'h00C8, 16'h0063);
      outs(3, 1'b0, 1'b0);
      setin(16'h0258, 16'h00C8, 16'h0064);
      outs(3, 1'b1, 1'b0);
      bus(mwd_pkg::IDX_TQ_SELECT, 1'b1, 32'h0);
      outs(3, 1'b0, 1'b0);
      chk("torque one", 32'h0, {31'h0, o_overtorque_detect_one});
      // Channel one alone: odd selection needs speed agree, time counts tenths
      bus(mwd_pkg::IDX_TQ_TIME, 1'b1, 32'h1);
      bus(mwd_pkg::IDX_TQ_SELECT, 1'b1, 32'h1);
      repeat (3) @(negedge i_ref_clk);
      chk("torque one", 32'h0, {31'h0, o_overtorque_detect_one});
      repeat (2) @(negedge i_ref_clk);
      chk("torque one", 32'h1, {31'h0, o_overtorque_detect_one});
      @(posedge i_ref_clk);
      i_speed_agree <= 1'b0;
      repeat (2) @(negedge i_ref_clk);
      chk("torque one", 32'h0, {31'h0, o_overtorque_detect_one});
      @(posedge i_ref_clk);
      i_speed_agree <= 1'b1;
      i_run <= 1'b0;
      repeat (7) @(negedge i_ref_clk);
      chk("torque one", 32'h0, {31'h0, o_overtorque_detect_one});
      @(posedge i_ref_clk);
      i_run <= 1'b1;
      repeat (6) @(negedge i_ref_clk);
      chk("torque one", 32'h1, {31'h0, o_overtorque_detect_one});
      bus(mwd_pkg::IDX_TQ_SELECT, 1'b1, 32'h6);
      repeat (2) @(negedge i_ref_clk);
      chk("torque one", 32'h0, {31'h0, o_overtorque_detect_one});
      setin(16'h0258, 16'h0064, 16'h0064);
      repeat (6) @(negedge i_ref_clk);
      chk("torque one", 32'h1, {31'h0, o_overtorque_detect_one});
      conclude();
   end
endmodule
